// ### core/edc_ctrl.sv
// edc_ctrl: host-side strobe sequencer for an asynchronous 1M x 16 page-mode dram.
// assumes the dram pins are wired straight to these ports and the user holds a
// request until it is accepted.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// [R1] wait 200 us after power-up, then eight refresh cycles before any access
// [R2] rerun the eight wake-up refreshes whenever the refresh period was missed
// [R3] refresh all 1024 rows inside every 16 ms
// [R4] in self-refresh the dram refreshes itself within 128 ms
// [R5] dram floats data while both strobes are high
// [R6] dram may keep driving last read data while a column strobe is low
// [R7] raise both strobes for column precharge to start a fresh cycle
// [R8] write strobe low before column strobe gives an early write, outputs open
// [R9] write strobe after the access delays gives a read-write cycle
// [R10] never sample data after a write between early and read-write timing
// [R11] output enable high and late write strobe gives a late write
// [R12] lower strobe owns data 7:0, upper strobe owns data 15:8
// [R13] raising output enable before column strobe rises floats data
// [R14] with output enable tied low only early writes are possible
// [R15] write strobe falling edge is the write command
// [R16] keep output enable high during late writes so outputs stay open
// [R17] data taken at column strobe fall in early write, write fall otherwise
// [R18] column-first refresh: column strobe before row strobe, write high
// [R19] row-only refresh: row address with only the row strobe pulsed
// [R20] hidden refresh after read: column low, write high, enable low
// [R21] hidden refresh after write: write low, output enable high
// [R22] dram turns data off after the later of the strobe rising edges
// [R23] row address before row strobe falls, column address before column strobe
// [R24] page mode keeps row low, cycles column strobes, within the page limit
module edc_ctrl #(
  parameter int PAUSE_CYC = edc_pkg::WAKE_PAUSE_CYC, // power-up pause
  parameter int REF_INTERVAL = edc_pkg::REF_INTERVAL_CYC, // cycles per row refresh
  parameter int PAGE_MAX = edc_pkg::PAGE_MAX_CYC // longest row-open time
) (
  input wire logic clk_i, // 50 MHz clock
  input wire logic sys_rst_i, // async reset, active high
  input wire logic req_valid_i, // access request
  input wire logic req_write_i, // 1 write, 0 read
  input wire logic [1:0] req_be_i, // byte lanes: bit1 upper, bit0 lower
  input wire logic [19:0] req_addr_i, // word address: row 19:10, col 9:0
  input wire logic [15:0] req_wdata_i, // write data
  input wire logic req_late_i, // write as late write (output enable controlled)
  input wire logic wake_again_i, // refresh budget was broken: redo wake-up
  output logic req_ready_o, // request accepted this cycle
  output logic rd_valid_o, // read data valid pulse
  output logic [15:0] rd_data_o, // read data
  output logic ready_o, // wake-up finished
  output logic [9:0] mem_addr_o, // multiplexed address
  output logic row_strobe_n_o, // row strobe
  output logic lower_byte_column_strobe_n_o, // lower lane column strobe
  output logic upper_byte_column_strobe_n_o, // upper lane column strobe
  output logic write_strobe_n_o, // write strobe
  output logic out_enable_n_o, // output enable
  input wire logic [15:0] mem_dq_i, // data pins in
  output logic [15:0] mem_dq_o, // data pins out
  output logic mem_dq_oe_o // drive data pins
);
  if (PAUSE_CYC < 2 || PAUSE_CYC > 65535 || PAGE_MAX < 2 || PAGE_MAX > 65535) begin
    $error("edc_ctrl pause or page limit out of range");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    edc_pkg::edc_state_e st;
    logic [3:0] wake_cnt;
    logic woke;
    logic write;
    logic late;
    logic [1:0] be;
    logic [9:0] row;
    logic [9:0] col;
    logic [15:0] wdata;
    logic rf_ack;
    logic tmr_load;
    logic [15:0] tmr_val;
    logic req_ready;
    logic rd_valid;
    logic [15:0] rd_data;
    logic [9:0] addr;
    logic ras_n;
    logic lower_byte_column_strobe_n_n;
    logic upper_byte_column_strobe_n_n;
    logic we_n;
    logic oe_n;
    logic [15:0] dq_o;
    logic dq_oe;
  } edc_ctrl_s;

  edc_ctrl_s s_r;
  edc_ctrl_s s_nxt;
  logic tmr_done;
  logic rf_req;
  logic [15:0] page_cnt_r;

  // converts a cycle count to a timer load (timer counts down to zero)
  function automatic logic [15:0] tload(input int cyc);
    tload = (cyc > 1) ? 16'(cyc - 1) : 16'h0000;
  endfunction

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  edc_timer #(.W(edc_pkg::TIMER_W)) u_timer (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .load_i(s_r.tmr_load),
    .value_i(s_r.tmr_val),
    .done_o(tmr_done)
  );

  edc_refresh_sched #(.INTERVAL(REF_INTERVAL)) u_sched (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .enable_i(s_r.woke),
    .ack_i(s_r.rf_ack),
    .req_o(rf_req)
  );

  // row-open age, used to close a page before its limit
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      page_cnt_r <= 16'h0000;
    end else if (s_r.ras_n) begin
      page_cnt_r <= 16'h0000;
    end else begin
      page_cnt_r <= page_cnt_r + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // timer loads happen one cycle after the state change, so the done flag is
  // only trusted when no load is pending
  always_comb begin
    logic go;
    logic page_hit;
    go = tmr_done && !s_r.tmr_load;
    page_hit = 1'b0;
    s_nxt = s_r;
    s_nxt.tmr_load = 1'b0;
    s_nxt.rf_ack = 1'b0;
    s_nxt.req_ready = 1'b0;
    s_nxt.rd_valid = 1'b0;
    unique case (s_r.st)
      edc_pkg::EDC_ST_PAUSE: begin
        if (go) begin
          s_nxt.wake_cnt = 4'h0;
          s_nxt.st = edc_pkg::EDC_ST_PRECH; // [R1]
          s_nxt.tmr_load = 1'b1;
          s_nxt.tmr_val = tload(edc_pkg::RAS_PRECHARGE_CYC);
        end
      end
      edc_pkg::EDC_ST_IDLE: begin
        if (wake_again_i) begin
          s_nxt.woke = 1'b0; // [R2]
          s_nxt.wake_cnt = 4'h0;
        end else if (!s_r.woke || rf_req) begin
          // column-first refresh: column strobes drop first, write held high
          s_nxt.we_n = 1'b1; // [R18]
          s_nxt.lower_byte_column_strobe_n_n = 1'b0;
          s_nxt.upper_byte_column_strobe_n_n = 1'b0;
          s_nxt.st = edc_pkg::EDC_ST_RFCAS; // [R19] [R20] [R21]
          s_nxt.tmr_load = 1'b1;
          s_nxt.tmr_val = tload(edc_pkg::CAS_PRECHARGE_CYC);
        end else if (req_valid_i && req_be_i != edc_pkg::BYTE_NONE) begin
          s_nxt.req_ready = 1'b1;
          s_nxt.write = req_write_i;
          s_nxt.late = req_late_i;
          s_nxt.be = req_be_i;
          s_nxt.row = req_addr_i[19:10];
          s_nxt.col = req_addr_i[9:0];
          s_nxt.wdata = req_wdata_i;
          s_nxt.addr = req_addr_i[19:10]; // [R23]
          s_nxt.st = edc_pkg::EDC_ST_ROW;
        end
      end
      edc_pkg::EDC_ST_ROW: begin
        // row address stood one cycle; now the row strobe falls
        s_nxt.ras_n = 1'b0;
        s_nxt.st = edc_pkg::EDC_ST_COL;
        s_nxt.tmr_load = 1'b1;
        s_nxt.tmr_val = tload(edc_pkg::RAS_TO_CAS_CYC);
      end
      edc_pkg::EDC_ST_COL: begin
        if (go) begin
          s_nxt.addr = s_r.col; // [R23]
          if (s_r.write) begin
            s_nxt.dq_o = s_r.wdata;
            s_nxt.dq_oe = 1'b1;
            s_nxt.oe_n = 1'b1; // [R14] [R16]
            if (!s_r.late) begin
              s_nxt.we_n = 1'b0; // [R8] [R15]
            end
          end else begin
            s_nxt.oe_n = 1'b0;
          end
          s_nxt.st = edc_pkg::EDC_ST_RDWAIT;
        end
      end
      edc_pkg::EDC_ST_RDWAIT: begin
        // column strobes fall a cycle after the column address, per lane
        s_nxt.lower_byte_column_strobe_n_n = !s_r.be[0]; // [R12]
        s_nxt.upper_byte_column_strobe_n_n = !s_r.be[1];
        s_nxt.st = edc_pkg::EDC_ST_WRPULSE;
        s_nxt.tmr_load = 1'b1;
        s_nxt.tmr_val = s_r.write ? tload(edc_pkg::WR_PULSE_CYC) : tload(edc_pkg::RAS_ACCESS_CYC);
      end
      edc_pkg::EDC_ST_WRPULSE: begin
        if (go) begin
          if (s_r.write && s_r.late && s_r.we_n) begin
            // late write: write strobe falls after the column strobe, enable high
            s_nxt.we_n = 1'b0; // [R11] [R17]
            s_nxt.tmr_load = 1'b1;
            s_nxt.tmr_val = tload(edc_pkg::WR_PULSE_CYC);
          end else begin
            if (!s_r.write) begin
              // sampled only on a clean read, never after a write
              s_nxt.rd_valid = 1'b1; // [R10]
              s_nxt.rd_data[7:0] = s_r.be[0] ? mem_dq_i[7:0] : 8'h00;
              s_nxt.rd_data[15:8] = s_r.be[1] ? mem_dq_i[15:8] : 8'h00;
            end
            // output enable up before the column strobes rise floats the bus
            s_nxt.oe_n = 1'b1; // [R13]
            s_nxt.st = edc_pkg::EDC_ST_CASHI;
          end
        end
      end
      edc_pkg::EDC_ST_CASHI: begin
        s_nxt.we_n = 1'b1;
        s_nxt.dq_oe = 1'b0;
        s_nxt.lower_byte_column_strobe_n_n = 1'b1;
        s_nxt.upper_byte_column_strobe_n_n = 1'b1;
        page_hit = req_valid_i && req_be_i != edc_pkg::BYTE_NONE && !rf_req && !wake_again_i &&
                   req_addr_i[19:10] == s_r.row && page_cnt_r < 16'(PAGE_MAX / 2);
        if (page_hit) begin
          // page mode: row stays low, new column address
          s_nxt.req_ready = 1'b1; // [R24]
          s_nxt.write = req_write_i;
          s_nxt.late = req_late_i;
          s_nxt.be = req_be_i;
          s_nxt.col = req_addr_i[9:0];
          s_nxt.wdata = req_wdata_i;
          s_nxt.st = edc_pkg::EDC_ST_COL;
          s_nxt.tmr_load = 1'b1;
          s_nxt.tmr_val = tload(edc_pkg::CAS_PRECHARGE_CYC);
        end else begin
          // both strobes high for precharge clears the dram output buffer
          s_nxt.ras_n = 1'b1; // [R7] [R24]
          s_nxt.st = edc_pkg::EDC_ST_PRECH;
          s_nxt.tmr_load = 1'b1;
          s_nxt.tmr_val = tload(edc_pkg::RAS_PRECHARGE_CYC);
        end
      end
      edc_pkg::EDC_ST_RFCAS: begin
        if (go) begin
          s_nxt.ras_n = 1'b0; // [R18]
          s_nxt.st = edc_pkg::EDC_ST_RFRAS;
          s_nxt.tmr_load = 1'b1;
          s_nxt.tmr_val = tload(edc_pkg::RAS_PULSE_CYC);
        end
      end
      edc_pkg::EDC_ST_RFRAS: begin
        if (go) begin
          s_nxt.ras_n = 1'b1;
          s_nxt.lower_byte_column_strobe_n_n = 1'b1;
          s_nxt.upper_byte_column_strobe_n_n = 1'b1;
          s_nxt.rf_ack = s_r.woke; // [R3]
          if (!s_r.woke) begin
            s_nxt.wake_cnt = s_r.wake_cnt + 4'h1;
            if (s_r.wake_cnt == 4'(edc_pkg::WAKE_REFRESH_CNT - 1)) begin
              s_nxt.woke = 1'b1; // [R1]
            end
          end
          s_nxt.st = edc_pkg::EDC_ST_PRECH;
          s_nxt.tmr_load = 1'b1;
          s_nxt.tmr_val = tload(edc_pkg::RAS_PRECHARGE_CYC);
        end
      end
      edc_pkg::EDC_ST_PRECH: begin
        if (go) begin
          s_nxt.st = edc_pkg::EDC_ST_IDLE;
        end
      end
      default: begin
        s_nxt.st = edc_pkg::EDC_ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // register
  // ----------------------------------------------------------------
  // reset loads the pause count so the timer starts the power-up wait
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_r <= '0;
      s_r.st <= edc_pkg::EDC_ST_PAUSE;
      s_r.tmr_load <= 1'b1;
      s_r.tmr_val <= tload(PAUSE_CYC);
      s_r.ras_n <= 1'b1;
      s_r.lower_byte_column_strobe_n_n <= 1'b1;
      s_r.upper_byte_column_strobe_n_n <= 1'b1;
      s_r.we_n <= 1'b1;
      s_r.oe_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign req_ready_o = s_r.req_ready;
  assign rd_valid_o = s_r.rd_valid;
  assign rd_data_o = s_r.rd_data;
  assign ready_o = s_r.woke;
  assign mem_addr_o = s_r.addr;
  assign row_strobe_n_o = s_r.ras_n;
  assign lower_byte_column_strobe_n_o = s_r.lower_byte_column_strobe_n_n;
  assign upper_byte_column_strobe_n_o = s_r.upper_byte_column_strobe_n_n;
  assign write_strobe_n_o = s_r.we_n;
  assign out_enable_n_o = s_r.oe_n;
  assign mem_dq_o = s_r.dq_o;
  assign mem_dq_oe_o = s_r.dq_oe;
endmodule
`default_nettype wire

// ### common/edc_pkg.sv
// edc_pkg: constants and types shared by the dram strobe controller files.
// assumes a 50 MHz system clock; all times are converted to cycle counts here.
package edc_pkg;
  localparam int CLK_MHZ = 50;
  localparam int CLK_NS = 20;
  // wake-up pause and refresh budget
  localparam int WAKE_PAUSE_US = 200;
  localparam int WAKE_PAUSE_CYC = WAKE_PAUSE_US * CLK_MHZ;
  localparam int WAKE_REFRESH_CNT = 8;
  localparam int REF_ROWS = 1024;
  localparam int REF_PERIOD_MS = 16;
  // one row every period/rows, rounded down so the budget is never overrun
  localparam int REF_INTERVAL_CYC = (REF_PERIOD_MS * 1000 * CLK_MHZ) / REF_ROWS;
  // strobe timing, rounded up to whole cycles
  localparam int RAS_PRECHARGE_NS = 30;
  localparam int RAS_PRECHARGE_CYC = (RAS_PRECHARGE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RAS_PULSE_NS = 50;
  localparam int RAS_PULSE_CYC = (RAS_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RAS_TO_CAS_NS = 12;
  localparam int RAS_TO_CAS_CYC = (RAS_TO_CAS_NS + CLK_NS - 1) / CLK_NS;
  localparam int RAS_ACCESS_NS = 50;
  localparam int RAS_ACCESS_CYC = (RAS_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int CAS_ACCESS_NS = 25;
  localparam int CAS_ACCESS_CYC = (CAS_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int CAS_PRECHARGE_NS = 9;
  localparam int CAS_PRECHARGE_CYC = (CAS_PRECHARGE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_PULSE_NS = 13;
  localparam int WR_PULSE_CYC = (WR_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int PAGE_MAX_NS = 100000;
  // page held at most this long, rounded down
  localparam int PAGE_MAX_CYC = PAGE_MAX_NS / CLK_NS;
  localparam int TIMER_W = 16;
  localparam logic [1:0] BYTE_BOTH = 2'h3;
  localparam logic [1:0] BYTE_NONE = 2'h0;

  typedef enum logic [3:0] {
    EDC_ST_PAUSE   = 4'h0,
    EDC_ST_IDLE    = 4'h1,
    EDC_ST_ROW     = 4'h2,
    EDC_ST_COL     = 4'h3,
    EDC_ST_RDWAIT  = 4'h4,
    EDC_ST_WRPULSE = 4'h5,
    EDC_ST_CASHI   = 4'h6,
    EDC_ST_PRECH   = 4'h7,
    EDC_ST_RFCAS   = 4'h8,
    EDC_ST_RFRAS   = 4'h9
  } edc_state_e;
endpackage

// ### core/edc_timer.sv
// edc_timer: loadable down counter reporting when it reaches zero.
// assumes the loader picks counts that fit the width.
`timescale 1ns/100ps
`default_nettype none
module edc_timer #(
  parameter int W = 16
) (
  input wire logic clk_i, // system clock
  input wire logic sys_rst_i, // async reset, active high
  input wire logic load_i, // load pulse
  input wire logic [W-1:0] value_i, // count to load
  output logic done_o // count is zero
);
  if (W < 2) begin
    $error("edc_timer width too small");
  end
  logic [W-1:0] cnt_r;
  // a load overrides counting so back-to-back phases never skip
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_r <= '0;
    end else if (load_i) begin
      cnt_r <= value_i;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end
  assign done_o = (cnt_r == '0);
endmodule
`default_nettype wire

// ### core/edc_refresh_sched.sv
// edc_refresh_sched: raises a sticky refresh request once per row interval.
// assumes the controller acknowledges each served row with a one-cycle pulse.
`timescale 1ns/100ps
`default_nettype none
module edc_refresh_sched #(
  parameter int INTERVAL = edc_pkg::REF_INTERVAL_CYC
) (
  input wire logic clk_i, // system clock
  input wire logic sys_rst_i, // async reset, active high
  input wire logic enable_i, // count only after wake-up
  input wire logic ack_i, // one row refreshed
  output logic req_o // refresh due
);
  if (INTERVAL < 2 || INTERVAL > 65535) begin
    $error("edc_refresh_sched interval out of range");
  end
  logic [15:0] tick_r;
  logic req_r;
  // a tick arriving with the ack keeps the request: set wins
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tick_r <= 16'h0000;
      req_r <= 1'b0;
    end else if (enable_i) begin
      if (tick_r == 16'(INTERVAL - 1)) begin
        tick_r <= 16'h0000;
        req_r <= 1'b1;
      end else begin
        tick_r <= tick_r + 16'h0001;
        if (ack_i) req_r <= 1'b0;
      end
    end
  end
  assign req_o = req_r;
endmodule
`default_nettype wire

// ### bench/edc_ctrl_checker.sv
// edc_ctrl_checker: pin-level protocol assertions for the dram strobe controller.
// assumes it is bound to edc_ctrl and sees nothing but that module's ports.
`timescale 1ns/100ps
`default_nettype none
module edc_ctrl_checker #(
  parameter int PAUSE_CYC = 20,
  parameter int REF_INTERVAL = 50,
  parameter int PAGE_MAX = 60
) (
  input wire logic clk_i, // clock
  input wire logic sys_rst_i, // reset
  input wire logic req_valid_i, // request
  input wire logic req_write_i, // write
  input wire logic [1:0] req_be_i, // lanes
  input wire logic [19:0] req_addr_i, // address
  input wire logic [15:0] req_wdata_i, // write data
  input wire logic req_late_i, // late write
  input wire logic wake_again_i, // redo wake-up
  input wire logic req_ready_o, // taken
  input wire logic rd_valid_o, // read done
  input wire logic [15:0] rd_data_o, // read data
  input wire logic ready_o, // awake
  input wire logic [9:0] mem_addr_o, // pin address
  input wire logic row_strobe_n_o, // row strobe
  input wire logic lower_byte_column_strobe_n_o, // lower strobe
  input wire logic upper_byte_column_strobe_n_o, // upper strobe
  input wire logic write_strobe_n_o, // write strobe
  input wire logic out_enable_n_o, // output enable
  input wire logic [15:0] mem_dq_i, // data in
  input wire logic [15:0] mem_dq_o, // data out
  input wire logic mem_dq_oe_o // data drive
);
  // ------
  // helper counters and assertions
  // ------
  logic cas_hi;
  logic ras_q;
  int cyc_r, falls_r, gap_r, open_r;
  assign cas_hi = lower_byte_column_strobe_n_o && upper_byte_column_strobe_n_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // gap only counts once awake, the wake-up sequence has its own bound
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ras_q <= 1'b1;
      cyc_r <= 0;
      falls_r <= 0;
      gap_r <= 0;
      open_r <= 0;
    end else begin
      ras_q <= row_strobe_n_o;
      cyc_r <= (cyc_r < PAUSE_CYC) ? cyc_r + 1 : cyc_r;
      falls_r <= ready_o ? 0 : falls_r + int'(ras_q && !row_strobe_n_o);
      gap_r <= (!ready_o || (ras_q && !row_strobe_n_o && !cas_hi)) ? 0 : gap_r + 1;
      open_r <= row_strobe_n_o ? 0 : open_r + 1;
    end
  end
  pause_hold_a: assert property (cyc_r < PAUSE_CYC |-> row_strobe_n_o)
    else $error("row strobe fell during the power-up pause");
  wake_count_a: assert property ($rose(ready_o) |-> falls_r == 8)
    else $error("ready rose without exactly eight wake-up row cycles");
  wake_redo_a: assert property (wake_again_i && ready_o && row_strobe_n_o |-> ##[1:100] !ready_o)
    else $error("wake-up request did not drop ready");
  refresh_gap_a: assert property (gap_r <= REF_INTERVAL + PAGE_MAX + 40)
    else $error("refresh interval overrun");
  cbr_order_a: assert property ($fell(row_strobe_n_o) && !cas_hi |-> write_strobe_n_o && !$past(cas_hi))
    else $error("column-first refresh out of order");
  precharge_a: assert property ($rose(row_strobe_n_o) |-> cas_hi ##1 (row_strobe_n_o && cas_hi))
    else $error("strobes not held high for precharge");
  row_addr_a: assert property ($fell(row_strobe_n_o) && cas_hi |-> $stable(mem_addr_o))
    else $error("row address moved at row strobe fall");
  col_addr_a: assert property ($fell(cas_hi) |-> $stable(mem_addr_o))
    else $error("column address moved at column strobe fall");
  late_oe_a: assert property (!write_strobe_n_o |-> out_enable_n_o && mem_dq_oe_o)
    else $error("write without output enable high and data driven");
  drive_clash_a: assert property (mem_dq_oe_o |-> out_enable_n_o)
    else $error("data driven while output enable low");
  page_limit_a: assert property (open_r < PAGE_MAX)
    else $error("row held open too long");
  taken_ok_a: assert property (req_ready_o |-> ready_o && $past(req_valid_i) && $past(req_be_i) != 2'h0)
    else $error("request taken when it should be refused");
  cover property ($rose(rd_valid_o));
  cover property ($fell(write_strobe_n_o) && !cas_hi);
  cover property ($fell(ready_o));
endmodule
bind edc_ctrl edc_ctrl_checker #(.PAUSE_CYC(PAUSE_CYC), .REF_INTERVAL(REF_INTERVAL), .PAGE_MAX(PAGE_MAX)) i_checker (
  .clk_i, .sys_rst_i, .req_valid_i, .req_write_i, .req_be_i, .req_addr_i, .req_wdata_i, .req_late_i,
  .wake_again_i, .req_ready_o, .rd_valid_o, .rd_data_o, .ready_o, .mem_addr_o, .row_strobe_n_o,
  .lower_byte_column_strobe_n_o, .upper_byte_column_strobe_n_o, .write_strobe_n_o, .out_enable_n_o,
  .mem_dq_i, .mem_dq_o, .mem_dq_oe_o);
`default_nettype wire

// ### bench/edc_dram_model.sv
// edc_dram_model: behavioural 1M x 16 page-mode dram with two byte strobes.
// assumes pins move just after clk_i edges; answers one cycle after a strobe.
`timescale 1ns/100ps
`default_nettype none
module edc_dram_model (
  input wire logic clk_i, // bench clock
  input wire logic row_strobe_n_i, // row strobe
  input wire logic lower_n_i, // lower column strobe
  input wire logic upper_n_i, // upper column strobe
  input wire logic write_strobe_n_i, // write strobe
  input wire logic out_enable_n_i, // output enable
  input wire logic [9:0] addr_i, // multiplexed address
  input wire logic [15:0] dq_i, // resolved data wire
  output var logic [15:0] dq_o, // device side of data
  output var int refresh_cnt_o // column-first refreshes
);
  // ------
  // storage and strobe decoding
  // ------
  logic [15:0] mem [int];
  logic [9:0] row_r = 10'h0, col_r = 10'h0;
  logic [3:0] prev_r = 4'hF;
  initial dq_o = 16'h0;
  initial refresh_cnt_o = 0;
  // undriven lanes flip every cycle so a stale sample can never match
  always @(posedge clk_i) begin
    logic [1:0] cas;
    logic [9:0] col;
    logic [15:0] word;
    int idx;
    cas = {upper_n_i, lower_n_i};
    col = (prev_r[2] && prev_r[1] && cas != 2'h3) ? addr_i : col_r;
    if (prev_r[3] && !row_strobe_n_i) begin
      if (cas == 2'h3) row_r <= addr_i;
      else if (write_strobe_n_i) refresh_cnt_o <= refresh_cnt_o + 1;
    end
    idx = {row_r, col};
    word = mem.exists(idx) ? mem[idx] : 16'h0;
    for (int k = 0; k < 2; k++) begin
      if (!row_strobe_n_i && !cas[k] && !write_strobe_n_i && (prev_r[2-k] || prev_r[0]))
        word[8*k +: 8] = dq_i[8*k +: 8];
      dq_o[8*k +: 8] <= (!cas[k] && !out_enable_n_i && write_strobe_n_i) ? word[8*k +: 8]
                        : ~dq_o[8*k +: 8];
    end
    mem[idx] = word;
    col_r <= col;
    prev_r <= {row_strobe_n_i, lower_n_i, upper_n_i, write_strobe_n_i};
  end
endmodule
`default_nettype wire

// ### bench/edc_ctrl_bench.sv
// edc_ctrl_bench: self-checking bench for edc_ctrl against a dram model.
// assumes the checker is bound in and short pause and refresh counts are legal.
`timescale 1ns/100ps
`default_nettype none
module edc_ctrl_bench;
  // ------
  // signals, instances and helpers
  // ------
  localparam int PAUSE = 20;
  localparam int REF = 50;
  localparam int PAGE = 60;
  localparam int LIMIT = 20000;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic req_valid_i = 1'b0, req_write_i = 1'b0, req_late_i = 1'b0, wake_again_i = 1'b0;
  logic [1:0] req_be_i = 2'h0;
  logic [19:0] req_addr_i = 20'h0;
  logic [15:0] req_wdata_i = 16'h0;
  logic req_ready_o, rd_valid_o, ready_o, row_n, lower_n, upper_n, we_n, oe_n, dq_oe;
  logic [15:0] rd_data_o, mem_dq_o, mem_dq_i, dev_dq;
  logic [9:0] mem_addr_o;
  int refreshes, num_errors = 0, n_compared = 0, cycles = 0;
  logic [15:0] shadow [int], expq [$];
  logic [19:0] addrs [$];
  assign mem_dq_i = dq_oe ? mem_dq_o : dev_dq;
  edc_ctrl #(.PAUSE_CYC(PAUSE), .REF_INTERVAL(REF), .PAGE_MAX(PAGE)) i_edc_ctrl (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_valid_i(req_valid_i), .req_write_i(req_write_i),
    .req_be_i(req_be_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .req_late_i(req_late_i),
    .wake_again_i(wake_again_i), .req_ready_o(req_ready_o), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
    .ready_o(ready_o), .mem_addr_o(mem_addr_o), .row_strobe_n_o(row_n), .lower_byte_column_strobe_n_o(lower_n),
    .upper_byte_column_strobe_n_o(upper_n), .write_strobe_n_o(we_n), .out_enable_n_o(oe_n),
    .mem_dq_i(mem_dq_i), .mem_dq_o(mem_dq_o), .mem_dq_oe_o(dq_oe));
  edc_dram_model i_edc_dram_model (
    .clk_i(clk_i), .row_strobe_n_i(row_n), .lower_n_i(lower_n), .upper_n_i(upper_n), .write_strobe_n_i(we_n),
    .out_enable_n_i(oe_n), .addr_i(mem_addr_o), .dq_i(mem_dq_i), .dq_o(dev_dq), .refresh_cnt_o(refreshes));
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  task automatic report_and_stop();
    if (num_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wait_level(input logic lvl);
    int n = 0;
    while (ready_o !== lvl && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    check({15'h0, ready_o}, {15'h0, lvl}, "ready level");
  endtask
  // hold the request until taken; reads leave their expectation for the monitor
  task automatic access(input logic wr, input logic late, input logic [1:0] be, input logic [19:0] a,
                        input logic [15:0] d);
    int n = 0;
    logic [15:0] m = {{8{be[1]}}, {8{be[0]}}};
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_write_i <= wr;
    req_late_i <= late;
    req_be_i <= be;
    req_addr_i <= a;
    req_wdata_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (req_ready_o !== 1'b1 && n < 500);
    req_valid_i <= 1'b0;
    check({15'h0, n < 500}, 16'h1, "request taken");
    if (wr) shadow[a] = ((shadow.exists(a) ? shadow[a] : 16'h0) & ~m) | (d & m);
    else expq.push_back((shadow.exists(a) ? shadow[a] : 16'h0) & m);
  endtask
  // monitor: every read result is matched against the oldest expectation
  always @(posedge clk_i) begin
    if (rd_valid_o === 1'b1) begin
      if (expq.size() == 0) check(16'h0, 16'h1, "unexpected read");
      else check(rd_data_o, expq.pop_front(), "read data");
    end
  end
  always @(posedge clk_i) begin
    if (++cycles == LIMIT) begin
      num_errors++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      report_and_stop();
    end
  end
  // ------
  // main sequence
  // ------
  initial begin
    logic [31:0] r;
    logic [19:0] a;
    int c0, n;
    void'($urandom(32'h2cd57278));
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    wait_level(1'b1);
    check({15'h0, refreshes >= 8}, 16'h1, "wake-up refreshes");
    // a request with no byte lane must never be taken
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_be_i <= 2'h0;
    n = 0;
    repeat (30) begin
      @(posedge clk_i);
      if (req_ready_o === 1'b1) n++;
    end
    req_valid_i <= 1'b0;
    check(16'(n), 16'h0, "empty lane request taken");
    // pairs share a row so the second access can stay in the page
    for (int i = 0; i < 24; i++) begin
      r = $urandom();
      a = {10'(i / 2 % 3), r[9:0]};
      addrs.push_back(a);
      access(1'b1, r[20], 2'(1 + i % 3), a, r[31:16]);
      if (r[21]) access(1'b0, 1'b0, 2'h3, a, 16'h0);
    end
    foreach (addrs[i]) access(1'b0, 1'b0, 2'(3 - i % 3), addrs[i], 16'h0);
    c0 = refreshes;
    repeat (6 * REF) @(posedge clk_i);
    check({15'h0, refreshes - c0 >= 5}, 16'h1, "idle refreshes");
    c0 = refreshes;
    wake_again_i <= 1'b1;
    wait_level(1'b0);
    wake_again_i <= 1'b0;
    wait_level(1'b1);
    check({15'h0, refreshes - c0 >= 8}, 16'h1, "repeated wake-up");
    for (int i = 0; i < 6; i++) access(1'b0, 1'b0, 2'h3, addrs[i], 16'h0);
    n = 0;
    while (expq.size() != 0 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    check({15'h0, expq.size() == 0}, 16'h1, "reads outstanding");
    report_and_stop();
  end
endmodule
`default_nettype wire
